// File: rtl/tmr_cfg_defines.svh
/*
 mode register offsets, field positions, reset values and codes for the two-channel timer mode block.
 assumes inclusion by bare name; definitions only.
*/
`ifndef TMR_CFG_DEFINES_SVH
`define TMR_CFG_DEFINES_SVH
`define CH0_MODE_OFFSET 8'h00
`define CH1_MODE_OFFSET 8'h04
`define CH_STATUS_OFFSET 8'h08
`define MODE_RESET 16'h0000
`define CKS_HI 15
`define CKS_LO 14
`define CCS_BIT 12
`define SPLIT_BIT 11
`define STS_HI 10
`define STS_LO 8
`define CIS_HI 7
`define CIS_LO 6
`define MD_HI 3
`define MD_LO 0
`define CH0_WMASK 16'hd7cf
`define CH1_WMASK 16'hdfcf
`define STS_SOFT 3'h0
`define STS_EDGE 3'h1
`define STS_BOTH 3'h2
`define STS_MASTER 3'h4
`define MD_INTERVAL 4'h0
`define MD_INTERVAL_IRQ 4'h1
`define MD_CAPTURE 4'h4
`define MD_CAPTURE_IRQ 4'h5
`define MD_EVENT 4'h6
`define MD_ONECOUNT 4'h8
`define MD_ONECOUNT_RETRIG 4'h9
`define MD_CAP_ONECOUNT 4'hc
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// File: rtl/tmr_cfg_pkg.sv
/*
 types for the two-channel timer mode block.
 assumes the defines header for numeric values.
*/
package tmr_cfg_pkg;
  typedef enum logic [4:0] {
    OP_IDLE = 5'h01,
    OP_INTERVAL = 5'h02,
    OP_CAPTURE = 5'h04,
    OP_EVENT = 5'h08,
    OP_ONECOUNT = 5'h10
  } op_t;

  typedef struct packed {
    logic valid;
    op_t op;
    logic start_irq;
    logic retrig;
    logic capture;
  } decode_t;

  typedef struct packed {
    logic count_en;
    logic start_trig;
    logic capture_trig;
    logic start_irq;
    logic counting;
  } ch_out_t;
endpackage : tmr_cfg_pkg

// File: rtl/tmr_channel.sv
/*
 one timer channel: count clock select, input edge detect, trigger select and mode decode.
 assumes prescaled clock enables and a pin input already synchronised to aclk.
*/
`timescale 1ns/1ps
`include "tmr_cfg_defines.svh"
module tmr_channel
  import tmr_cfg_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] mode,
  input wire logic [3:0] prescaled_en,
  input wire logic pin_sync,
  input wire logic sw_start,
  input wire logic sw_stop,
  input wire logic master_irq,
  output ch_out_t out,
  output logic [WIDTH-1:0] count
);
  function automatic decode_t decode_mode(input logic [15:0] m);
    decode_t d;
    d = '{valid: 1'b1, op: OP_IDLE, start_irq: 1'b0, retrig: 1'b0, capture: 1'b0};
    case (m[`MD_HI:`MD_LO])
      `MD_INTERVAL: d.op = OP_INTERVAL;
      `MD_INTERVAL_IRQ:
      begin
        d.op = OP_INTERVAL;
        d.start_irq = 1'b1;
      end
      `MD_CAPTURE:
      begin
        d.op = OP_CAPTURE;
        d.capture = 1'b1;
      end
      `MD_CAPTURE_IRQ:
      begin
        d.op = OP_CAPTURE;
        d.capture = 1'b1;
        d.start_irq = 1'b1;
      end
      `MD_EVENT: d.op = OP_EVENT;
      `MD_ONECOUNT: d.op = OP_ONECOUNT;
      `MD_ONECOUNT_RETRIG:
      begin
        d.op = OP_ONECOUNT;
        d.retrig = 1'b1;
      end
      `MD_CAP_ONECOUNT:
      begin
        d.op = OP_ONECOUNT;
        d.capture = 1'b1;
      end
      default: d.valid = 1'b0;
    endcase
    case (m[`STS_HI:`STS_LO])
      `STS_SOFT, `STS_EDGE, `STS_BOTH, `STS_MASTER: d.valid = d.valid;
      default: d.valid = 1'b0;
    endcase
    return d;
  endfunction : decode_mode

  typedef struct packed {
    logic pin_prev;
    logic counting;
    ch_out_t out;
    logic [WIDTH-1:0] count;
  } state_t;

  state_t s_q, s_d;
  decode_t dec;
  logic rise, fall, valid_edge, mck_en, tick, trig, start_ok;

  always_comb
  begin
    dec = decode_mode(mode);
    rise = pin_sync & ~s_q.pin_prev;
    fall = ~pin_sync & s_q.pin_prev;
    case (mode[`CIS_HI:`CIS_LO])
      2'h0: valid_edge = fall;
      2'h1: valid_edge = rise;
      default: valid_edge = rise | fall;
    endcase
    case (mode[`CKS_HI:`CKS_LO])
      2'h0: mck_en = prescaled_en[0];
      2'h1: mck_en = prescaled_en[2];
      2'h2: mck_en = prescaled_en[1];
      default: mck_en = prescaled_en[3];
    endcase
    tick = mode[`CCS_BIT] ? valid_edge : mck_en;
    case (mode[`STS_HI:`STS_LO])
      `STS_EDGE: trig = sw_start | valid_edge;
      `STS_BOTH: trig = sw_start | rise | fall;
      `STS_MASTER: trig = sw_start | master_irq;
      default: trig = sw_start;
    endcase
    // capture modes turn a trigger during counting into a capture, not a restart
    start_ok = trig & dec.valid & (~s_q.counting | (~dec.capture & ((dec.op != OP_ONECOUNT) | dec.retrig)));
    s_d = s_q;
    s_d.pin_prev = pin_sync;
    s_d.out.start_trig = start_ok;
    s_d.out.capture_trig = dec.valid & dec.capture & s_q.counting & trig & ~start_ok;
    s_d.out.start_irq = start_ok & ~s_q.counting & dec.start_irq;
    s_d.out.count_en = s_q.counting & tick;
    if (sw_stop || !dec.valid)
    begin
      s_d.counting = 1'b0;
    end
    else if (start_ok)
    begin
      s_d.counting = 1'b1;
      s_d.count = '0;
    end
    else if (s_q.counting && tick)
    begin
      s_d.count = s_q.count + 1'b1;
    end
    s_d.out.counting = s_d.counting;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign out = s_q.out;
  assign count = s_q.count;

  AST_IDLE_ON_BAD: assert property (@(posedge aclk) disable iff (!aresetn)
    !dec.valid |=> !s_q.counting) else $error("counting on prohibited code");
  AST_SOFT_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode[`STS_HI:`STS_LO] == `STS_SOFT && !sw_start) |=> !out.start_trig) else $error("non-software start");
  AST_ONECOUNT_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode[`MD_HI:`MD_LO] == `MD_ONECOUNT && s_q.counting) |=> !out.start_trig) else $error("retrigger taken");
  AST_NO_IRQ_EVENT: assert property (@(posedge aclk) disable iff (!aresetn)
    mode[`MD_HI:`MD_LO] == `MD_EVENT |=> !out.start_irq) else $error("irq in event mode");
  AST_EXT_TICK: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode[`CCS_BIT] && s_q.counting && !valid_edge && !sw_stop) |=> !out.count_en) else $error("tick without edge");
endmodule : tmr_channel

// File: rtl/tmr_mode_cfg.sv
/*
 two-channel timer mode configuration with an AXI4-Lite register slave.
 assumes prescaled clock enables are one-cycle pulses on aclk; pins are asynchronous.
*/
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
// Function
// - bits 15-14 pick prescaled clock 0, 2, 1 or 3 for codes 00, 01, 10, 11.
// - channel 0 bit 12 picks master clock at 0 and input pin valid edges at 1.
// - trigger code 000 allows only the software start.
// - trigger code 001 uses the selected pin edge as start and capture trigger.
// - trigger code 010 uses both pin edges as start and capture trigger.
// - trigger code 100 uses the master channel interrupt as trigger.
// - bits 7-6 pick falling, rising, both (low width), both (high width) edges.
// - mode 0000 is interval without start interrupt, 0001 interval with it.
// - mode 0100 is capture without start interrupt, 0101 capture with it.
// - mode 0110 is event counting with no start interrupt.
// - mode 1000 is one-count ignoring restarts, 1001 one-count honouring them.
// - mode 1100 is capture and one-count, no start interrupt, restarts ignored.
// - channel 1 bit 12 at 1 counts on its own pin valid edges.
// - channel 1 bit 11 picks one 16-bit counter at 0, 8-bit counters at 1; here bit 11 only zeroes the high byte of ch1_count.
`timescale 1ns/1ps
`include "tmr_cfg_defines.svh"
module tmr_mode_cfg
  import tmr_cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] prescaled_en,
  input wire logic ch0_external_input,
  input wire logic ch1_external_input,
  input wire logic [1:0] sw_start,
  input wire logic [1:0] sw_stop,
  output ch_out_t ch0_status,
  output ch_out_t ch1_status,
  output logic [15:0] ch0_count,
  output logic [15:0] ch1_count
);
  typedef struct packed {
    logic [1:0] sync0;
    logic [1:0] sync1;
    logic [15:0] channel0_mode;
    logic [15:0] channel1_mode;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t s_q, s_d;
  ch_out_t st0, st1;
  logic [15:0] cnt0, cnt1, ch1_mode_eff;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] strb, input logic [15:0] wmask);
    logic [15:0] v;
    v = old;
    if (strb[0])
      v[7:0] = d[7:0];
    if (strb[1])
      v[15:8] = d[15:8];
    return v & wmask;
  endfunction : merge

  tmr_channel #(.WIDTH(16)) u_ch0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(s_q.channel0_mode),
    .prescaled_en(prescaled_en),
    .pin_sync(s_q.sync0[1]),
    .sw_start(sw_start[0]),
    .sw_stop(sw_stop[0]),
    .master_irq(1'b0),
    .out(st0),
    .count(cnt0)
  );

  // channel 1 slaves off channel 0 start interrupt
  tmr_channel #(.WIDTH(16)) u_ch1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(ch1_mode_eff),
    .prescaled_en(prescaled_en),
    .pin_sync(s_q.sync1[1]),
    .sw_start(sw_start[1]),
    .sw_stop(sw_stop[1]),
    .master_irq(st0.start_irq),
    .out(st1),
    .count(cnt1)
  );

  always_comb
  begin
    ch1_mode_eff = s_q.channel1_mode;
    s_d = s_q;
    s_d.sync0 = {s_q.sync0[0], ch0_external_input};
    s_d.sync1 = {s_q.sync1[0], ch1_external_input};
    if (s_axi_awvalid && !s_q.aw_held)
    begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !s_q.w_held)
    begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid)
    begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `AXI_OKAY;
      case (s_q.aw_addr)
        `CH0_MODE_OFFSET: s_d.channel0_mode = merge(s_q.channel0_mode, s_q.w_data, s_q.w_strb, `CH0_WMASK);
        `CH1_MODE_OFFSET: s_d.channel1_mode = merge(s_q.channel1_mode, s_q.w_data, s_q.w_strb, `CH1_WMASK);
        `CH_STATUS_OFFSET: s_d.bresp = `AXI_OKAY;
        default: s_d.bresp = `AXI_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;
    if (s_axi_arvalid && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `AXI_OKAY;
      case (s_axi_araddr[7:0])
        `CH0_MODE_OFFSET: s_d.rdata = {16'h0000, s_q.channel0_mode};
        `CH1_MODE_OFFSET: s_d.rdata = {16'h0000, s_q.channel1_mode};
        `CH_STATUS_OFFSET: s_d.rdata = {22'h000000, s_q.channel1_mode[`SPLIT_BIT], st1.counting, st0.counting,
                                        s_q.sync1[1], s_q.sync0[1], 5'h00};
        default:
        begin
          s_d.rdata = 32'h00000000;
          s_d.rresp = `AXI_SLVERR;
        end
      endcase
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.channel0_mode <= `MODE_RESET;
      s_q.channel1_mode <= `MODE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.aw_held;
  assign s_axi_wready = !s_q.w_held;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign ch0_status = st0;
  assign ch1_status = st1;
  assign ch0_count = cnt0;
  // split mode: only the low 8 bits of the one 16-bit counter reach ch1_count, high byte forced to zero
  assign ch1_count = s_q.channel1_mode[`SPLIT_BIT] ? {cnt1[15:8], cnt1[7:0]} & 16'h00ff : cnt1;

  AST_CH0_BIT11_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    !s_q.channel0_mode[`SPLIT_BIT]) else $error("channel 0 bit 11 set");
  AST_SPLIT_HIGH_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.channel1_mode[`SPLIT_BIT] |-> ch1_count[15:8] == 8'h00) else $error("split high byte nonzero");
  AST_B_AFTER_AW: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.aw_held && s_q.w_held && !s_q.bvalid) |=> s_axi_bvalid) else $error("write response late");
endmodule : tmr_mode_cfg

// File: tb/tmr_far_side.sv
/*
 far side model: prescaled clock enables and the two timer input pins.
 assumes one aclk domain; pins toggle every 3 cycles while pin_run is high.
*/
`timescale 1ns/1ps
module tmr_far_side
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_run,
  output logic [3:0] prescaled_en,
  output logic ch0_external_input,
  output logic ch1_external_input
);
  localparam int PERIOD [4] = '{2, 3, 5, 7};
  logic [2:0] div_q [4];
  logic [1:0] pin_cnt_q;
  logic pin_q;
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < 4; i++)
      div_q[i] <= (!aresetn || div_q[i] == 3'(PERIOD[i] - 1)) ? 3'h0 : div_q[i] + 3'h1;
    pin_cnt_q <= (!aresetn || !pin_run || pin_cnt_q == 2'h2) ? 2'h0 : pin_cnt_q + 2'h1;
    if (!aresetn)
      pin_q <= 1'b0;
    else if (pin_run && pin_cnt_q == 2'h2)
      pin_q <= ~pin_q;
  end
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      prescaled_en[i] = aresetn && div_q[i] == 3'h0;
  end
  assign ch0_external_input = pin_q;
  assign ch1_external_input = ~pin_q;
endmodule : tmr_far_side

// File: tb/tmr_mode_cfg_tb.sv
/*
 testbench for the timer mode block: AXI4-Lite register tasks and mode cases.
 assumes the far side model supplies prescaled enables with periods 2, 3, 5, 7.
*/
`timescale 1ns/1ps
`include "tmr_cfg_defines.svh"
module tmr_mode_cfg_tb
  import tmr_cfg_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0] prescaled_en;
  logic ch0_external_input, ch1_external_input;
  logic [1:0] sw_start = 2'h0, sw_stop = 2'h0;
  ch_out_t ch0_status, ch1_status;
  logic [15:0] ch0_count, ch1_count;
  logic pin_run = 1'b0;
  logic tally_on = 1'b0;
  logic irq_seen = 1'b0;
  logic cap_seen = 1'b0;
  logic [1:0] r;
  logic [31:0] d;
  int ticks = 0;
  int error_cnt = 0;
  int comparisons = 0;

  tmr_mode_cfg u_dut (.*);
  tmr_far_side u_far (.*);

  always #4 aclk = ~aclk;

  always @(posedge aclk)
  begin
    if (tally_on && ch0_status.count_en === 1'b1)
      ticks++;
    if (ch0_status.start_irq === 1'b1)
      irq_seen = 1'b1;
    if (ch0_status.capture_trig === 1'b1)
      cap_seen = 1'b1;
  end

  task automatic finish_test;
    if (error_cnt == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic give_up(input int n);
    if (n >= 100)
    begin
      error_cnt++;
      $display("BAD %0t bus wait ran out", $time);
      finish_test();
    end
  endtask : give_up

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 100);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    give_up(n);
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 100);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    give_up(n);
  endtask : axi_rd

  // stop, reprogram channel 0, start by software or pin, then observe
  task automatic run_case(input logic [15:0] m, input logic pin, input logic sw,
                          input int c, input int q, input int t);
    pin_run <= 1'b0;
    repeat (6) @(posedge aclk);
    sw_stop <= 2'h3;
    @(posedge aclk);
    sw_stop <= 2'h0;
    axi_wr(`CH0_MODE_OFFSET, {16'h0, m}, r);
    irq_seen = 1'b0;
    cap_seen = 1'b0;
    @(posedge aclk);
    pin_run <= pin;
    sw_start <= {1'b0, sw};
    @(posedge aclk);
    sw_start <= 2'h0;
    repeat (20) @(posedge aclk);
    ticks = 0;
    tally_on <= 1'b1;
    repeat (210) @(posedge aclk);
    tally_on <= 1'b0;
    if (c >= 0)
      check({31'h0, ch0_status.counting}, 32'(c));
    check({31'h0, irq_seen}, 32'(q));
    if (t >= 0)
      check(32'(ticks), 32'(t));
  endtask : run_case

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`CH0_MODE_OFFSET, d, r);
    check(d, 32'h0);
    axi_rd(`CH1_MODE_OFFSET, d, r);
    check(d, 32'h0);
    axi_wr(`CH0_MODE_OFFSET, 32'hffffffff, r);
    axi_rd(`CH0_MODE_OFFSET, d, r);
    check(d, 32'hd7cf);
    axi_wr(`CH1_MODE_OFFSET, 32'hffffffff, r);
    axi_rd(`CH1_MODE_OFFSET, d, r);
    check(d, 32'hdfcf);
    axi_wr(`CH1_MODE_OFFSET, 32'h0800, r);
    axi_rd(`CH_STATUS_OFFSET, d, r);
    check({31'h0, d[9]}, 32'h1);
    axi_wr(32'h10, 32'h1, r);
    check({30'h0, r}, {30'h0, `AXI_SLVERR});
    axi_rd(32'h10, d, r);
    check({30'h0, r}, {30'h0, `AXI_SLVERR});
    run_case(16'h0000, 1'b0, 1'b1, 1, 0, 105);
    run_case(16'h4000, 1'b0, 1'b1, 1, 0, 42);
    run_case(16'h8000, 1'b0, 1'b1, 1, 0, 70);
    run_case(16'hc001, 1'b0, 1'b1, 1, 1, 30);
    run_case(16'h1040, 1'b1, 1'b1, 1, 0, 35);
    run_case(16'h1000, 1'b1, 1'b1, 1, 0, 35);
    run_case(16'h1080, 1'b1, 1'b1, 1, 0, 70);
    run_case(16'h10c0, 1'b1, 1'b1, 1, 0, 70);
    run_case(16'h0004, 1'b0, 1'b1, 1, 0, -1);
    run_case(16'h0005, 1'b0, 1'b1, 1, 1, -1);
    run_case(16'h0006, 1'b0, 1'b1, 1, 0, -1);
    run_case(16'h0008, 1'b0, 1'b1, -1, 0, -1);
    run_case(16'h0009, 1'b0, 1'b1, -1, 0, -1);
    run_case(16'h000c, 1'b0, 1'b1, -1, 0, -1);
    run_case(16'h0002, 1'b0, 1'b1, 0, 0, -1);
    run_case(16'h0000, 1'b1, 1'b0, 0, 0, -1);
    run_case(16'h0100, 1'b1, 1'b0, 1, 0, -1);
    check({31'h0, cap_seen}, 32'h0);
    run_case(16'h0104, 1'b1, 1'b0, 1, 0, -1);
    check({31'h0, cap_seen}, 32'h1);
    run_case(16'h0200, 1'b1, 1'b0, 1, 0, -1);
    run_case(16'h0300, 1'b1, 1'b0, 0, 0, -1);
    axi_wr(`CH1_MODE_OFFSET, 32'h0400, r);
    run_case(16'h0000, 1'b0, 1'b1, 1, 0, -1);
    check({31'h0, ch1_status.counting}, 32'h0);
    run_case(16'h0001, 1'b0, 1'b1, 1, 1, -1);
    check({31'h0, ch1_status.counting}, 32'h1);
    finish_test();
  end
endmodule : tmr_mode_cfg_tb
